// ==== design/osc_retune_device.sv ====
// Oscillator retune control: dividers, multiplier commit, calibration, gate
`timescale 1ns/1ns
`include "osc_retune_regs.svh"

module osc_retune_device
	import osc_retune_pkg::*;
#(
	parameter int SETTLE_CYCLES = `CAL_SETTLE_CYCLES,
	parameter logic [7:0] PROD_FLOOR = 8'h14,
	parameter logic [7:0] PROD_CEIL = 8'hfa,
	parameter logic [8:0] RESET_M_INT = 9'h044,
	parameter logic [28:0] RESET_M_FRAC = 29'h02a4_433e,
	parameter logic [9:0] RESET_HIGH_SPEED_DIVIDER = 10'h02a,
	parameter logic [2:0] RESET_LS_FIELD = 3'h0,
	parameter logic [3:0] RESET_LOOP_FIRST = 4'h3,
	parameter logic [3:0] RESET_LOOP_SECOND = 4'h3
) (
	input wire logic core_clk,
	input wire logic rst_b,
	osc_reg_if.dev bus,
	output logic clk_out_enable,
	output logic cal_start,
	output logic cal_busy,
	output logic [8:0] active_m_int,
	output logic [28:0] active_m_frac,
	output logic [9:0] high_speed_divider,
	output logic [2:0] low_speed_divider,
	output logic [5:0] low_speed_ratio,
	output logic [3:0] loop_comp_first,
	output logic [3:0] loop_comp_second,
	output logic divider_product_ok
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES);

	// Staged multiplier bytes, pending until the upper integer write
	logic [28:0] staged_frac;
	logic [2:0] staged_int_lo;
	logic oe_bit;
	logic [CNT_W-1:0] settle_cnt;
	reg_byte_t read_value;
	logic [7:0] divider_product_floor;
	logic [7:0] divider_product_ceiling;

	// Address decode of write strobes
	wire wr_lp = bus.wr_stb && (bus.addr == `ADDR_LOOP_COMP);
	wire wr_f0 = bus.wr_stb && (bus.addr == `ADDR_FRAC_0);
	wire wr_f1 = bus.wr_stb && (bus.addr == `ADDR_FRAC_1);
	wire wr_f2 = bus.wr_stb && (bus.addr == `ADDR_FRAC_2);
	wire wr_f3 = bus.wr_stb && (bus.addr == `ADDR_FRAC_3);
	wire wr_int = bus.wr_stb && (bus.addr == `ADDR_INT_HI);
	wire wr_hs = bus.wr_stb && (bus.addr == `ADDR_HS_LO);
	wire wr_dh = bus.wr_stb && (bus.addr == `ADDR_DIV_HI);
	wire wr_ctrl = bus.wr_stb && (bus.addr == `ADDR_CTRL);

	// Only an explicit trigger write starts calibration
	wire cal_trigger = wr_ctrl && bus.wdata[`CTRL_CAL_BIT];

	// Product limits are fixed per part and only readable
	assign divider_product_floor = PROD_FLOOR;
	assign divider_product_ceiling = PROD_CEIL;

	// Low-speed field encodes log2 of the ratio, zero is bypass
	assign low_speed_ratio = 6'h01 << low_speed_divider;

	// Legal divider settings
	wire hs_legal = !high_speed_divider[0] &&
		(high_speed_divider >= `HIGH_SPEED_DIVIDER_MIN) &&
		(high_speed_divider <= `HIGH_SPEED_DIVIDER_MAX);
	wire ls_legal = (low_speed_divider <= `LS_FIELD_MAX);
	wire [15:0] divider_product =
		{6'h00, high_speed_divider} << low_speed_divider;

	// Product must sit inside the per-part window
	assign divider_product_ok = hs_legal && ls_legal &&
		(divider_product >= {8'h00, divider_product_floor}) &&
		(divider_product <= {8'h00, divider_product_ceiling});

	// Busy while the oscillator settles on the new center
	assign cal_busy = (settle_cnt != '0);

	// Readback selection; trigger bit always reads zero
	assign read_value =
		(bus.addr == `ADDR_LOOP_COMP) ?
			{loop_comp_first, loop_comp_second} :
		(bus.addr == `ADDR_FRAC_0) ? staged_frac[7:0] :
		(bus.addr == `ADDR_FRAC_1) ? staged_frac[15:8] :
		(bus.addr == `ADDR_FRAC_2) ? staged_frac[23:16] :
		(bus.addr == `ADDR_FRAC_3) ?
			{staged_int_lo, staged_frac[28:24]} :
		(bus.addr == `ADDR_INT_HI) ? {2'b00, active_m_int[8:3]} :
		(bus.addr == `ADDR_HS_LO) ? high_speed_divider[7:0] :
		(bus.addr == `ADDR_DIV_HI) ?
			{1'b0, low_speed_divider, 2'b00, high_speed_divider[9:8]} :
		(bus.addr == `ADDR_PROD_FLOOR) ? divider_product_floor :
		(bus.addr == `ADDR_PROD_CEIL) ? divider_product_ceiling :
		(bus.addr == `ADDR_CTRL) ? {5'h00, oe_bit, 2'b00} :
		8'h00;

	// Read port: data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.rdata <= 8'h00;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= bus.rd_stb;
			if (bus.rd_stb) begin
				bus.rdata <= read_value;
			end
		end
	end

	// Loop compensation pair, applied on write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_comp_first <= RESET_LOOP_FIRST;
			loop_comp_second <= RESET_LOOP_SECOND;
		end else if (wr_lp) begin
			loop_comp_first <= bus.wdata[7:4];
			loop_comp_second <= bus.wdata[3:0];
		end
	end

	// Fraction bytes are staged, not yet effective
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			staged_frac <= RESET_M_FRAC;
			staged_int_lo <= RESET_M_INT[2:0];
		end else begin
			if (wr_f0) begin
				staged_frac[7:0] <= bus.wdata;
			end
			if (wr_f1) begin
				staged_frac[15:8] <= bus.wdata;
			end
			if (wr_f2) begin
				staged_frac[23:16] <= bus.wdata;
			end
			if (wr_f3) begin
				staged_frac[28:24] <= bus.wdata[4:0];
				staged_int_lo <= bus.wdata[7:5];
			end
		end
	end

	// Upper integer write commits the whole multiplier at once
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_m_int <= RESET_M_INT;
			active_m_frac <= RESET_M_FRAC;
		end else if (wr_int) begin
			active_m_int <= {bus.wdata[5:0], staged_int_lo};
			active_m_frac <= staged_frac;
		end
	end

	// Output dividers, effective on write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			high_speed_divider <= RESET_HIGH_SPEED_DIVIDER;
			low_speed_divider <= RESET_LS_FIELD;
		end else begin
			if (wr_hs) begin
				high_speed_divider[7:0] <= bus.wdata;
			end
			if (wr_dh) begin
				high_speed_divider[9:8] <= bus.wdata[1:0];
				low_speed_divider <= bus.wdata[6:4];
			end
		end
	end

	// Output enable bit; the trigger bit is never stored
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_bit <= 1'b1;
		end else if (wr_ctrl) begin
			oe_bit <= bus.wdata[`CTRL_OE_BIT];
		end
	end

	// Settling counter; a repeated trigger restarts the interval
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle_cnt <= '0;
		end else if (cal_trigger) begin
			settle_cnt <= SETTLE_LOAD;
		end else if (cal_busy) begin
			settle_cnt <= settle_cnt - 1'b1;
		end
	end

	// Calibration start pulse towards the analog core
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_start <= 1'b0;
		end else begin
			cal_start <= cal_trigger;
		end
	end

	// Clock gate: off while disabled, calibrating or out of limits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_out_enable <= 1'b0;
		end else begin
			clk_out_enable <= oe_bit && divider_product_ok &&
				!cal_busy && !cal_trigger;
		end
	end

endmodule // osc_retune_device

// ==== design/osc_retune_regs.svh ====
// Register offsets, field positions, limits and timing counts for the retune
`ifndef OSC_RETUNE_REGS_SVH
`define OSC_RETUNE_REGS_SVH

// Register offsets
`define ADDR_LOOP_COMP 8'h00
`define ADDR_FRAC_0 8'h05
`define ADDR_FRAC_1 8'h06
`define ADDR_FRAC_2 8'h07
`define ADDR_FRAC_3 8'h08
`define ADDR_INT_HI 8'h09
`define ADDR_HS_LO 8'h0a
`define ADDR_DIV_HI 8'h0b
`define ADDR_PROD_FLOOR 8'h30
`define ADDR_PROD_CEIL 8'h31
`define ADDR_CTRL 8'h84

// Field positions in the control register
`define CTRL_CAL_BIT 0
`define CTRL_OE_BIT 2
`define CTRL_DISABLE 8'h00
`define CTRL_CAL 8'h01
`define CTRL_ENABLE 8'h04

// Divider limits
`define HIGH_SPEED_DIVIDER_MIN 10'h00a
`define HIGH_SPEED_DIVIDER_MAX 10'h3fe
`define LS_FIELD_MAX 3'h5

// Multiplier thresholds for loop compensation, int.frac fixed point
`define LC_TH_44 38'h9_7afc_06fa
`define LC_TH_34 38'h9_1e01_061a
`define LC_TH_33 38'h8_7b83_2eaa
`define LC_TH_23 38'h8_2851_c217

// Settling after a calibration trigger
`define CORE_CLK_MHZ 25
`define CAL_SETTLE_US 10000
`define CAL_SETTLE_CYCLES (`CAL_SETTLE_US * `CORE_CLK_MHZ)

`endif

// ==== design/osc_retune_pkg.sv ====
// Types shared by the two ends of the retune link
package osc_retune_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef enum logic [1:0] {
		H_IDLE,
		H_LOAD,
		H_SETTLE,
		H_RESTORE
	} host_state_e;
endpackage

// ==== design/osc_reg_if.sv ====
// Register access link between host controller and oscillator control
`timescale 1ns/1ns
interface osc_reg_if;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	modport dev(input wr_stb, input rd_stb, input addr, input wdata,
		output rdata, output rvalid);
	modport host(output wr_stb, output rd_stb, output addr, output wdata,
		input rdata, input rvalid);
endinterface

// ==== design/osc_retune_host.sv ====
// Host controller end: sequences a large retune over the register link
`timescale 1ns/1ns
`include "osc_retune_regs.svh"

module osc_retune_host
	import osc_retune_pkg::*;
#(
	parameter int SETTLE_CYCLES = `CAL_SETTLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	osc_reg_if.host bus,
	input wire logic start,
	input wire logic [2:0] target_ls_field,
	input wire logic [9:0] target_high_speed_divider,
	input wire logic [8:0] target_m_int,
	input wire logic [28:0] target_m_frac,
	output logic busy,
	output logic done,
	output logic refused
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES);
	localparam logic [3:0] LAST_STEP = 4'h9;

	host_state_e state;
	host_state_e next_state;
	logic [3:0] step;
	logic [CNT_W-1:0] wait_cnt;
	logic [2:0] lat_ls;
	logic [9:0] lat_hs;
	logic [8:0] lat_int;
	logic [28:0] lat_frac;
	logic [7:0] lat_lp;
	logic [7:0] step_addr;
	logic [7:0] step_data;
	logic [7:0] lp_pick;

	// Targets must use legal divider settings
	wire [37:0] m_fixed = {target_m_int, target_m_frac};
	wire target_legal = (target_ls_field <= `LS_FIELD_MAX) &&
		!target_high_speed_divider[0] && (target_high_speed_divider >= `HIGH_SPEED_DIVIDER_MIN) &&
		(target_high_speed_divider <= `HIGH_SPEED_DIVIDER_MAX);
	wire accept = (state == H_IDLE) && start && target_legal;

	// Loop compensation pair from multiplier thresholds
	assign lp_pick = (m_fixed > `LC_TH_44) ? 8'h44 :
		(m_fixed > `LC_TH_34) ? 8'h34 :
		(m_fixed > `LC_TH_33) ? 8'h33 :
		(m_fixed > `LC_TH_23) ? 8'h23 : 8'h22;

	// Write sequence: disable, values, fraction before integer, trigger
	assign step_addr = (step == 4'h0) ? `ADDR_CTRL :
		(step == 4'h1) ? `ADDR_LOOP_COMP :
		(step == 4'h2) ? `ADDR_FRAC_0 :
		(step == 4'h3) ? `ADDR_FRAC_1 :
		(step == 4'h4) ? `ADDR_FRAC_2 :
		(step == 4'h5) ? `ADDR_FRAC_3 :
		(step == 4'h6) ? `ADDR_INT_HI :
		(step == 4'h7) ? `ADDR_HS_LO :
		(step == 4'h8) ? `ADDR_DIV_HI : `ADDR_CTRL;
	assign step_data = (step == 4'h0) ? `CTRL_DISABLE :
		(step == 4'h1) ? lat_lp :
		(step == 4'h2) ? lat_frac[7:0] :
		(step == 4'h3) ? lat_frac[15:8] :
		(step == 4'h4) ? lat_frac[23:16] :
		(step == 4'h5) ? {lat_int[2:0], lat_frac[28:24]} :
		(step == 4'h6) ? {2'b00, lat_int[8:3]} :
		(step == 4'h7) ? lat_hs[7:0] :
		(step == 4'h8) ? {1'b0, lat_ls, 2'b00, lat_hs[9:8]} :
		`CTRL_CAL;

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			H_IDLE: begin
				if (accept) begin
					next_state = H_LOAD;
				end
			end
			H_LOAD: begin
				if (step == LAST_STEP) begin
					next_state = H_SETTLE;
				end
			end
			H_SETTLE: begin
				if (wait_cnt == '0) begin
					next_state = H_RESTORE;
				end
			end
			H_RESTORE: begin
				next_state = H_IDLE;
			end
		endcase
	end

	assign busy = (state != H_IDLE);

	// State, step and wait counters
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= H_IDLE;
			step <= 4'h0;
			wait_cnt <= '0;
		end else begin
			state <= next_state;
			step <= (state == H_LOAD) ? step + 4'h1 : 4'h0;
			if (state == H_LOAD) begin
				wait_cnt <= SETTLE_LOAD;
			end else if (wait_cnt != '0) begin
				wait_cnt <= wait_cnt - 1'b1;
			end
		end
	end

	// Latch targets when a retune is accepted
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lat_ls <= 3'h0;
			lat_hs <= 10'h000;
			lat_int <= 9'h000;
			lat_frac <= 29'h000_0000;
			lat_lp <= 8'h00;
		end else if (accept) begin
			lat_ls <= target_ls_field;
			lat_hs <= target_high_speed_divider;
			lat_int <= target_m_int;
			lat_frac <= target_m_frac;
			lat_lp <= lp_pick;
		end
	end

	// Registered bus outputs and status pulses
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.addr <= 8'h00;
			bus.wdata <= 8'h00;
			done <= 1'b0;
			refused <= 1'b0;
		end else begin
			bus.wr_stb <= (state == H_LOAD) || (state == H_RESTORE);
			bus.rd_stb <= 1'b0;
			bus.addr <= (state == H_RESTORE) ? `ADDR_CTRL : step_addr;
			bus.wdata <= (state == H_RESTORE) ? `CTRL_ENABLE :
				step_data;
			done <= (state == H_RESTORE);
			refused <= (state == H_IDLE) && start && !target_legal;
		end
	end

endmodule // osc_retune_host

// ==== tb/osc_retune_properties.sv ====
// Assertions on the link between retune host and device
`timescale 1ns/1ns
module osc_retune_properties #(
	parameter int SETTLE_CYCLES = 20
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wr_stb,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic cal_start,
	input wire logic cal_busy,
	input wire logic clk_out_enable,
	input wire logic [8:0] active_m_int,
	input wire logic [28:0] active_m_frac,
	input wire logic divider_product_ok
);
	localparam int SETTLE_MAX = SETTLE_CYCLES + 1;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Control register writes seen on the link
	sequence s_trigger;
		wr_stb && addr == 8'h84 && wdata[0];
	endsequence
	sequence s_oe_on;
		wr_stb && addr == 8'h84 && wdata[2] && divider_product_ok;
	endsequence
	// Calibration start, gating and settling
	property p_cal_on_trigger;
		s_trigger |=> cal_start;
	endproperty
	a_cal_on_trigger: assert property (p_cal_on_trigger)
		else $error("no calibration after trigger");
	property p_no_self_cal;
		cal_start |-> $past(wr_stb && addr == 8'h84 && wdata[0]);
	endproperty
	a_no_self_cal: assert property (p_no_self_cal)
		else $error("calibration without trigger");
	property p_gate_in_cal;
		cal_start |-> !clk_out_enable;
	endproperty
	a_gate_in_cal: assert property (p_gate_in_cal)
		else $error("output enabled at calibration");
	property p_settle;
		cal_start |-> ##[1:SETTLE_MAX] !cal_busy;
	endproperty
	a_settle: assert property (p_settle)
		else $error("settling too long");
	// Multiplier commit and write order
	property p_commit;
		$changed({active_m_int, active_m_frac})
			|-> $past(wr_stb && addr == 8'h09);
	endproperty
	a_commit: assert property (p_commit)
		else $error("multiplier changed without commit");
	property p_int_last;
		wr_stb && addr == 8'h09 |-> $past(wr_stb && addr == 8'h08);
	endproperty
	a_int_last: assert property (p_int_last)
		else $error("upper integer before fraction");
	property p_oe_first;
		wr_stb && addr == 8'h00
			|-> $past(wr_stb && addr == 8'h84 && wdata == 8'h00);
	endproperty
	a_oe_first: assert property (p_oe_first)
		else $error("output not disabled first");
	// Output gate follows enable and divider limits
	property p_restore;
		s_oe_on |=> ##1 clk_out_enable;
	endproperty
	a_restore: assert property (p_restore)
		else $error("output not restored");
	property p_product;
		!divider_product_ok |=> !clk_out_enable;
	endproperty
	a_product: assert property (p_product)
		else $error("output on with bad dividers");
endmodule // osc_retune_properties

// ==== tb/testbench.sv ====
// Self-checking bench for the retune host and device
`timescale 1ns/1ns
`include "osc_retune_regs.svh"
module testbench;
	logic core_clk = 0;
	logic rst_b = 0;
	logic start = 0;
	logic [2:0] ls = 0;
	logic [9:0] hs = 0;
	logic [8:0] mi = 0;
	logic [28:0] mf = 0;
	logic busy, done, refused, oe, cs, cb, ok, oe2, cs2, cb2;
	logic [8:0] ami, ami2;
	logic [28:0] amf, amf2;
	logic [9:0] hsd;
	logic [2:0] lsd;
	logic [5:0] lsr;
	logic [3:0] lcf, lcs;
	logic [7:0] rd_val;
	int bad_count = 0;
	int checks_done = 0;
	int cal2 = 0;
	osc_reg_if link();
	osc_reg_if drv();
	always #20 core_clk = ~core_clk;
	// Count calibrations of the directly driven device
	always @(negedge core_clk) if (cs2 === 1) cal2++;
	osc_retune_host #(.SETTLE_CYCLES(20)) osc_retune_host_i (
		.core_clk(core_clk), .rst_b(rst_b), .bus(link.host), .start(start),
		.target_ls_field(ls), .target_high_speed_divider(hs), .target_m_int(mi),
		.target_m_frac(mf), .busy(busy), .done(done), .refused(refused));
	osc_retune_device #(.SETTLE_CYCLES(20)) osc_retune_device_i (
		.core_clk(core_clk), .rst_b(rst_b), .bus(link.dev),
		.clk_out_enable(oe), .cal_start(cs), .cal_busy(cb),
		.active_m_int(ami), .active_m_frac(amf),
		.high_speed_divider(hsd), .low_speed_divider(lsd),
		.low_speed_ratio(lsr), .loop_comp_first(lcf),
		.loop_comp_second(lcs), .divider_product_ok(ok));
	osc_retune_device #(.SETTLE_CYCLES(20)) osc_retune_device_b_i (
		.core_clk(core_clk), .rst_b(rst_b), .bus(drv.dev),
		.clk_out_enable(oe2), .cal_start(cs2), .cal_busy(cb2),
		.active_m_int(ami2), .active_m_frac(amf2),
		.high_speed_divider(), .low_speed_divider(),
		.low_speed_ratio(), .loop_comp_first(),
		.loop_comp_second(), .divider_product_ok());
	osc_retune_properties #(.SETTLE_CYCLES(20)) osc_retune_properties_i (
		.core_clk(core_clk), .rst_b(rst_b), .wr_stb(link.wr_stb),
		.addr(link.addr), .wdata(link.wdata), .cal_start(cs),
		.cal_busy(cb), .clk_out_enable(oe), .active_m_int(ami),
		.active_m_frac(amf), .divider_product_ok(ok));
	// Verdict and end of run
	task automatic test_done();
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [37:0] exp,
		input logic [37:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask
	// Register writes and reads on the directly driven device
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		drv.wr_stb = 1;
		drv.addr = a;
		drv.wdata = d;
		@(negedge core_clk);
		drv.wr_stb = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(negedge core_clk);
		drv.rd_stb = 1;
		drv.addr = a;
		@(negedge core_clk);
		drv.rd_stb = 0;
		for (n = 0; n < 4 && drv.rvalid !== 1; n++) begin
			@(negedge core_clk);
		end
		if (n == 4) begin
			check("rvalid wait", 1, 0);
			test_done();
		end
		rd_val = drv.rdata;
	endtask
	// Stage fraction bytes without the upper integer byte
	task automatic wm(input logic [8:0] i, input logic [28:0] f);
		wr(8'h05, f[7:0]);
		wr(8'h06, f[15:8]);
		wr(8'h07, f[23:16]);
		wr(8'h08, {i[2:0], f[28:24]});
	endtask
	// Full retune through the host, judged at the device
	task automatic t_retune(input logic [37:0] m, input logic [7:0] l,
		input logic [2:0] s, input logic [9:0] h, input logic e);
		int n;
		int cals;
		logic glitch;
		cals = 0;
		glitch = 0;
		@(negedge core_clk);
		{mi, mf} = m;
		ls = s;
		hs = h;
		start = 1;
		@(negedge core_clk);
		start = 0;
		for (n = 0; n < 200 && done !== 1; n++) begin
			@(negedge core_clk);
			if (cs === 1) cals++;
			if (cb === 1 && oe !== 0) glitch = 1;
		end
		if (n == 200) begin
			check("done wait", 1, 0);
			test_done();
		end
		check("calibrations", 1, cals);
		check("output in settling", 0, glitch);
		check("multiplier int", m[37:29], ami);
		check("multiplier frac", m[28:0], amf);
		check("high speed divider", h, hsd);
		check("low speed field", s, lsd);
		check("low speed ratio", 6'h01 << s, lsr);
		check("loop compensation", l, {lcf, lcs});
		// Enable write lands one edge after done, the gate one edge later
		repeat (2) @(negedge core_clk);
		check("output enable", e, oe);
	endtask
	// Illegal dividers give one refusal and no traffic
	task automatic t_refuse(input logic [2:0] s, input logic [9:0] h);
		int n;
		int seen;
		seen = 0;
		@(negedge core_clk);
		ls = s;
		hs = h;
		start = 1;
		@(negedge core_clk);
		start = 0;
		for (n = 0; n < 4; n++) begin
			if (refused === 1) seen++;
			if (link.wr_stb === 1 || busy === 1) seen += 8;
			@(negedge core_clk);
		end
		check("refusals", 1, seen);
	endtask
	// Commit, trigger, retrigger and readback on the second device
	task automatic t_direct();
		wm(9'h046, 29'h0b68_39a3);
		wr(8'h09, 8'h08);
		wm(9'h041, 29'h014d_0215);
		@(negedge core_clk);
		check("held frac", 29'h0b68_39a3, amf2);
		rd(8'h08);
		check("staged byte", 8'h21, rd_val);
		wr(8'h09, 8'h08);
		wr(8'h0b, 8'h00);
		wr(8'h0a, 8'h2a);
		@(negedge core_clk);
		check("committed frac", 29'h014d_0215, amf2);
		check("committed int", 9'h041, ami2);
		check("self calibrations", 0, cal2);
		wr(8'h84, 8'h05);
		rd(8'h84);
		check("control readback", 8'h04, rd_val);
		check("calibrations", 1, cal2);
		repeat (10) @(negedge core_clk);
		wr(8'h84, 8'h05);
		repeat (15) @(negedge core_clk);
		check("busy after retrigger", 1, cb2);
		check("retrigger calibrations", 2, cal2);
		repeat (8) @(negedge core_clk);
		check("busy after settling", 0, cb2);
		check("output restored", 1, oe2);
		wr(8'h84, 8'h00);
		repeat (2) @(negedge core_clk);
		check("output disabled", 0, oe2);
		wr(8'h31, 8'h00);
		rd(8'h31);
		check("product ceiling", 8'hfa, rd_val);
		rd(8'h30);
		check("product floor", 8'h14, rd_val);
		rd(8'h01);
		check("unmapped read", 8'h00, rd_val);
	endtask
	// Main sequence
	initial begin
		drv.wr_stb = 0;
		drv.rd_stb = 0;
		drv.addr = 0;
		drv.wdata = 0;
		repeat (12) @(negedge core_clk);
		rst_b = 1;
		@(negedge core_clk);
		check("enable after reset", 1, oe);
		t_retune({9'h044, 29'h02a4_4557}, 8'h33, 3'h0, 10'h02a, 1);
		t_retune(`LC_TH_44, 8'h34, 3'h1, 10'h00a, 1);
		t_retune(`LC_TH_44 + 38'h1, 8'h44, 3'h3, 10'h01e, 1);
		t_retune(`LC_TH_34, 8'h33, 3'h0, 10'h00a, 0);
		t_retune(`LC_TH_33 + 38'h1, 8'h33, 3'h5, 10'h00a, 0);
		t_retune(`LC_TH_23, 8'h22, 3'h0, 10'h3fe, 0);
		t_retune(`LC_TH_23 + 38'h1, 8'h23, 3'h2, 10'h03e, 1);
		t_refuse(3'h6, 10'h02a);
		t_refuse(3'h0, 10'h00b);
		t_refuse(3'h0, 10'h008);
		t_direct();
		test_done();
	end
endmodule // testbench
